// ### shared/ddca_pkg.sv
`default_nettype none
package ddca_pkg;
    localparam int DDCA_ADDR_W = 17;
    localparam int DDCA_RANKS = 4;
    localparam int DDCA_RANK_W = 2;
    localparam int DDCA_BG_W = 2;
    localparam int DDCA_BA_W = 2;
    localparam int DDCA_CHANS = 2;
    // Address bits that carry command lines when the activate pin is high
    localparam int DDCA_RAS_BIT = 16;
    localparam int DDCA_CAS_BIT = 15;
    localparam int DDCA_WE_BIT = 14;
    localparam int DDCA_CMD_LO = 14;
    localparam int DDCA_AP_BIT = 10;
    localparam int DDCA_MR_BG_BIT = 1;
    // Reset and idle values of the pins
    localparam logic [DDCA_ADDR_W-1:0] DDCA_ADDR_IDLE = 17'h1c000;
    localparam logic [DDCA_RANKS-1:0] DDCA_CS_IDLE = 4'hf;
    localparam logic [DDCA_BG_W-1:0] DDCA_BG_IDLE = 2'h0;
    localparam logic [DDCA_BA_W-1:0] DDCA_BA_IDLE = 2'h0;
    // Idle state number at and beyond which the termination regulator is off
    localparam logic [3:0] DDCA_CSTATE_VTT_OFF = 4'h8;

    typedef enum logic [2:0] {
        DDCA_OP_ACT,
        DDCA_OP_RD,
        DDCA_OP_WR,
        DDCA_OP_PRE,
        DDCA_OP_PREA,
        DDCA_OP_MRS,
        DDCA_OP_REF,
        DDCA_OP_NOP
    } ddca_op_t;

    // Returns {ras_n, cas_n, we_n}
    function automatic logic [2:0] ddca_cmd_lines(input ddca_op_t op);
        logic [2:0] r;
        r = 3'h7;
        case (op)
            DDCA_OP_RD: r = 3'h5;
            DDCA_OP_WR: r = 3'h4;
            DDCA_OP_PRE: r = 3'h2;
            DDCA_OP_PREA: r = 3'h2;
            DDCA_OP_MRS: r = 3'h0;
            DDCA_OP_REF: r = 3'h1;
            default: r = 3'h7;
        endcase
        return r;
    endfunction : ddca_cmd_lines

    function automatic logic [DDCA_RANKS-1:0] ddca_cs_decode(input logic [DDCA_RANK_W-1:0] rank);
        return ~(4'h1 << rank);
    endfunction : ddca_cs_decode

    // Parity bit that makes the protected lines plus itself even
    function automatic logic ddca_even_par(input logic act_n, input logic [DDCA_ADDR_W-1:0] addr,
                                           input logic [DDCA_BG_W-1:0] bg, input logic [DDCA_BA_W-1:0] ba);
        return ^{act_n, addr, bg, ba};
    endfunction : ddca_even_par
endpackage : ddca_pkg
`default_nettype wire

// ### core/ddca_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module ddca_sync2
    import ddca_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb
    begin
        meta_d = d;
        sync_d = meta_q;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end
        else if (ce)
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q = sync_q;
endmodule : ddca_sync2
`default_nettype wire

// ### core/ddca_sync3.sv
`timescale 1ns/1ns
`default_nettype none
module ddca_sync3
    import ddca_pkg::*;
#(
    parameter logic RST_VAL = 1'b1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic out_q;
    logic out_d;

    // A change counts only once the second and third stages agree
    always_comb
    begin
        stage_d = {stage_q[1:0], d};
        out_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : out_q;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            stage_q <= {3{RST_VAL}};
            out_q <= RST_VAL;
        end
        else if (ce)
        begin
            stage_q <= stage_d;
            out_q <= out_d;
        end
    end

    assign q = out_q;
endmodule : ddca_sync3
`default_nettype wire

// ### core/ddca_cmd_driver.sv
// What this block does
// - With activate high and chip select low, A16/A15/A14 carry RAS/CAS/WE.
// - Bank group lines select the bank group of Activate, Read, Write, Precharge.
// - In a mode register set, bank group bit 0 helps select the register.
// - Bank address lines select the bank inside the group for those commands.
// - In a mode register set, bank address with BG0 selects the register.
// - Alert is sampled only in command training, as the parity error flag.
// - No write CRC; alert is never taken as a CRC error.
// - A parity output accompanies every command and address transfer.
// - Termination regulator control stays high while the regulator is needed.
// - Termination regulator control goes low in C8 or deeper, or S3.
// - One chip select per rank; only the addressed rank is selected.
// - Precharge drives A10 low for one bank, high for all banks.
`timescale 1ns/1ns
`default_nettype none
module ddca_cmd_driver
    import ddca_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic link_clk,
    input wire logic link_rst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_chan,
    input wire ddca_op_t cmd_op,
    input wire logic [DDCA_RANK_W-1:0] cmd_rank,
    input wire logic [DDCA_BG_W-1:0] cmd_bg,
    input wire logic [DDCA_BA_W-1:0] cmd_ba,
    input wire logic [DDCA_ADDR_W-1:0] cmd_addr,
    input wire logic training_en,
    input wire logic [3:0] idle_cstate,
    input wire logic s3_entry,
    input wire logic chan0_alert_in_n,
    input wire logic chan1_alert_in_n,
    output logic chan0_activate_n,
    output logic [DDCA_ADDR_W-1:0] chan0_addr,
    output logic [DDCA_BG_W-1:0] chan0_bg,
    output logic [DDCA_BA_W-1:0] chan0_ba,
    output logic [DDCA_RANKS-1:0] chan0_cs_n,
    output logic chan0_cmd_parity,
    output logic chan0_ca_parity_err,
    output logic chan1_activate_n,
    output logic [DDCA_ADDR_W-1:0] chan1_addr,
    output logic [DDCA_BG_W-1:0] chan1_bg,
    output logic [DDCA_BA_W-1:0] chan1_ba,
    output logic [DDCA_RANKS-1:0] chan1_cs_n,
    output logic chan1_cmd_parity,
    output logic chan1_ca_parity_err,
    output logic term_regulator_enable
);
    typedef enum logic {DDCA_ST_IDLE, DDCA_ST_WAIT} ddca_state_t;

    // Controller side, clk domain
    ddca_state_t state_q;
    ddca_state_t state_d;
    logic ready_q;
    logic ready_d;
    logic req_tgl_q;
    logic req_tgl_d;
    logic pl_chan_q;
    logic pl_chan_d;
    ddca_op_t pl_op_q;
    ddca_op_t pl_op_d;
    logic [DDCA_RANK_W-1:0] pl_rank_q;
    logic [DDCA_RANK_W-1:0] pl_rank_d;
    logic [DDCA_BG_W-1:0] pl_bg_q;
    logic [DDCA_BG_W-1:0] pl_bg_d;
    logic [DDCA_BA_W-1:0] pl_ba_q;
    logic [DDCA_BA_W-1:0] pl_ba_d;
    logic [DDCA_ADDR_W-1:0] pl_addr_q;
    logic [DDCA_ADDR_W-1:0] pl_addr_d;
    logic vtt_q;
    logic vtt_d;
    logic [1:0] alert_prev_q;
    logic [1:0] alert_prev_d;
    logic [1:0] err_q;
    logic [1:0] err_d;
    logic ack_s;
    logic [1:0] alert_lvl;
    logic take;

    // Link side, link_clk domain
    logic req_s;
    logic seen_q;
    logic seen_d;
    logic fire_q;
    logic fire_d;
    logic [1:0] act_q;
    logic [1:0] act_d;
    logic [DDCA_ADDR_W-1:0] addr_q [DDCA_CHANS];
    logic [DDCA_ADDR_W-1:0] addr_d [DDCA_CHANS];
    logic [DDCA_BG_W-1:0] bg_q [DDCA_CHANS];
    logic [DDCA_BG_W-1:0] bg_d [DDCA_CHANS];
    logic [DDCA_BA_W-1:0] ba_q [DDCA_CHANS];
    logic [DDCA_BA_W-1:0] ba_d [DDCA_CHANS];
    logic [DDCA_RANKS-1:0] cs_q [DDCA_CHANS];
    logic [DDCA_RANKS-1:0] cs_d [DDCA_CHANS];
    logic [1:0] par_q;
    logic [1:0] par_d;

    ddca_sync2 #(.RST_VAL(1'b0)) u_ack_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(seen_q),
        .q(ack_s)
    );

    ddca_sync2 #(.RST_VAL(1'b0)) u_req_sync (
        .clk(link_clk),
        .rst_n(link_rst_n),
        .ce(1'b1),
        .d(req_tgl_q),
        .q(req_s)
    );

    // Alert is active low and idles high
    ddca_sync3 #(.RST_VAL(1'b1)) u_alert0_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(chan0_alert_in_n),
        .q(alert_lvl[0])
    );

    ddca_sync3 #(.RST_VAL(1'b1)) u_alert1_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(chan1_alert_in_n),
        .q(alert_lvl[1])
    );

    assign take = cmd_valid && ready_q;

    // Payload stays frozen until the link side has echoed the toggle back
    always_comb
    begin
        state_d = state_q;
        req_tgl_d = req_tgl_q;
        pl_chan_d = pl_chan_q;
        pl_op_d = pl_op_q;
        pl_rank_d = pl_rank_q;
        pl_bg_d = pl_bg_q;
        pl_ba_d = pl_ba_q;
        pl_addr_d = pl_addr_q;
        case (state_q)
            DDCA_ST_IDLE:
            begin
                if (take)
                begin
                    pl_chan_d = cmd_chan;
                    pl_op_d = cmd_op;
                    pl_rank_d = cmd_rank;
                    pl_bg_d = cmd_bg;
                    pl_ba_d = cmd_ba;
                    pl_addr_d = cmd_addr;
                    req_tgl_d = ~req_tgl_q;
                    state_d = DDCA_ST_WAIT;
                end
            end
            DDCA_ST_WAIT:
            begin
                if (ack_s == req_tgl_q)
                begin
                    state_d = DDCA_ST_IDLE;
                end
            end
            default: state_d = DDCA_ST_IDLE;
        endcase
        ready_d = (state_d == DDCA_ST_IDLE);
    end

    // Regulator control and training alert, both in clk domain
    always_comb
    begin
        vtt_d = !((idle_cstate >= DDCA_CSTATE_VTT_OFF) || s3_entry);
        alert_prev_d = alert_lvl;
        // Only a falling alert during training is a parity error; no CRC path exists
        err_d = training_en ? (alert_prev_q & ~alert_lvl) : 2'h0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= DDCA_ST_IDLE;
            ready_q <= 1'b0;
            req_tgl_q <= 1'b0;
            pl_chan_q <= 1'b0;
            pl_op_q <= DDCA_OP_NOP;
            pl_rank_q <= '0;
            pl_bg_q <= DDCA_BG_IDLE;
            pl_ba_q <= DDCA_BA_IDLE;
            pl_addr_q <= DDCA_ADDR_IDLE;
            vtt_q <= 1'b1;
            alert_prev_q <= 2'h3;
            err_q <= 2'h0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            ready_q <= ready_d;
            req_tgl_q <= req_tgl_d;
            pl_chan_q <= pl_chan_d;
            pl_op_q <= pl_op_d;
            pl_rank_q <= pl_rank_d;
            pl_bg_q <= pl_bg_d;
            pl_ba_q <= pl_ba_d;
            pl_addr_q <= pl_addr_d;
            vtt_q <= vtt_d;
            alert_prev_q <= alert_prev_d;
            err_q <= err_d;
        end
    end

    // Pin encoder; a command stands for one link cycle, deselect otherwise
    always_comb
    begin
        seen_d = req_s;
        fire_d = (req_s != seen_q);
        for (int c = 0; c < DDCA_CHANS; c++)
        begin
            act_d[c] = 1'b1;
            addr_d[c] = DDCA_ADDR_IDLE;
            bg_d[c] = DDCA_BG_IDLE;
            ba_d[c] = DDCA_BA_IDLE;
            cs_d[c] = DDCA_CS_IDLE;
            if (fire_d && (pl_chan_q == 1'(c)) && (pl_op_q != DDCA_OP_NOP))
            begin
                cs_d[c] = ddca_cs_decode(pl_rank_q);
                bg_d[c] = pl_bg_q;
                ba_d[c] = pl_ba_q;
                if (pl_op_q == DDCA_OP_ACT)
                begin
                    act_d[c] = 1'b0;
                    addr_d[c] = pl_addr_q;
                end
                else
                begin
                    addr_d[c] = {ddca_cmd_lines(pl_op_q), pl_addr_q[DDCA_CMD_LO-1:0]};
                    case (pl_op_q)
                        DDCA_OP_PRE: addr_d[c][DDCA_AP_BIT] = 1'b0;
                        DDCA_OP_PREA: addr_d[c][DDCA_AP_BIT] = 1'b1;
                        DDCA_OP_MRS: bg_d[c][DDCA_MR_BG_BIT] = 1'b0;
                        default: addr_d[c] = addr_d[c];
                    endcase
                end
            end
            par_d[c] = ddca_even_par(act_d[c], addr_d[c], bg_d[c], ba_d[c]);
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
        begin
            seen_q <= 1'b0;
            fire_q <= 1'b0;
            act_q <= 2'h3;
            par_q <= 2'h0;
            for (int c = 0; c < DDCA_CHANS; c++)
            begin
                addr_q[c] <= DDCA_ADDR_IDLE;
                bg_q[c] <= DDCA_BG_IDLE;
                ba_q[c] <= DDCA_BA_IDLE;
                cs_q[c] <= DDCA_CS_IDLE;
            end
        end
        else
        begin
            seen_q <= seen_d;
            fire_q <= fire_d;
            act_q <= act_d;
            par_q <= par_d;
            for (int c = 0; c < DDCA_CHANS; c++)
            begin
                addr_q[c] <= addr_d[c];
                bg_q[c] <= bg_d[c];
                ba_q[c] <= ba_d[c];
                cs_q[c] <= cs_d[c];
            end
        end
    end

    assign cmd_ready = ready_q;
    assign term_regulator_enable = vtt_q;
    assign chan0_ca_parity_err = err_q[0];
    assign chan1_ca_parity_err = err_q[1];
    assign chan0_activate_n = act_q[0];
    assign chan0_addr = addr_q[0];
    assign chan0_bg = bg_q[0];
    assign chan0_ba = ba_q[0];
    assign chan0_cs_n = cs_q[0];
    assign chan0_cmd_parity = par_q[0];
    assign chan1_activate_n = act_q[1];
    assign chan1_addr = addr_q[1];
    assign chan1_bg = bg_q[1];
    assign chan1_ba = ba_q[1];
    assign chan1_cs_n = cs_q[1];
    assign chan1_cmd_parity = par_q[1];

    // Checks
    sequence s_take;
        ce && cmd_valid && ready_q;
    endsequence

    sequence s_hold_busy;
        !ready_q ##1 !ready_q;
    endsequence

    a_handshake_busy: assert property (@(posedge clk) disable iff (!rst_n) s_take |=> s_hold_busy)
        else $error("Ready returned before the link echoed the command");

    a_parity_even: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        ^{chan0_activate_n, chan0_addr, chan0_bg, chan0_ba, chan0_cmd_parity} == 1'b0)
        else $error("Channel 0 parity is not even");

    a_parity_one: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        ^{chan1_activate_n, chan1_addr, chan1_bg, chan1_ba, chan1_cmd_parity} == 1'b0)
        else $error("Channel 1 parity is not even");

    a_rank_select: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        $onehot0(~chan0_cs_n) && (fire_q || chan0_cs_n == DDCA_CS_IDLE))
        else $error("Chip select drives more than one rank or outside a command");

    a_read_lines: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        (fire_q && !pl_chan_q && pl_op_q == DDCA_OP_RD)
        |-> (chan0_activate_n && chan0_addr[DDCA_RAS_BIT:DDCA_WE_BIT] == 3'h5 && chan0_bg == pl_bg_q))
        else $error("Read command lines or bank group wrong");

    a_precharge_a10: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        (fire_q && !pl_chan_q && (pl_op_q == DDCA_OP_PRE || pl_op_q == DDCA_OP_PREA))
        |-> (chan0_addr[DDCA_AP_BIT] == (pl_op_q == DDCA_OP_PREA) && chan0_ba == pl_ba_q))
        else $error("Precharge A10 or bank wrong");

    a_mrs_select: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        (fire_q && !pl_chan_q && pl_op_q == DDCA_OP_MRS)
        |-> (chan0_bg == {1'b0, pl_bg_q[0]} && chan0_ba == pl_ba_q && chan0_addr[16:14] == 3'h0))
        else $error("Mode register selection wrong");

    a_alert_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !training_en) |=> !err_q[0] && !err_q[1])
        else $error("Alert flagged outside training");

    a_alert_flag: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && training_en && alert_prev_q[0] && !alert_lvl[0]) |=> err_q[0])
        else $error("Alert in training not flagged");

    a_vtt_off: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && (idle_cstate >= DDCA_CSTATE_VTT_OFF || s3_entry)) |=> !term_regulator_enable)
        else $error("Regulator left on in deep sleep");

    a_vtt_on: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && idle_cstate < DDCA_CSTATE_VTT_OFF && !s3_entry) |=> term_regulator_enable)
        else $error("Regulator off while needed");
endmodule : ddca_cmd_driver
`default_nettype wire

// ### verif/ddca_rank_model.sv
`timescale 1ns/1ns
`default_nettype none
module ddca_rank_model
    import ddca_pkg::*;
(
    input wire logic link_clk,
    input wire logic activate_n,
    input wire logic [DDCA_ADDR_W-1:0] addr,
    input wire logic [DDCA_BG_W-1:0] bg,
    input wire logic [DDCA_BA_W-1:0] ba,
    input wire logic [DDCA_RANKS-1:0] cs_n,
    input wire logic cmd_parity,
    input wire logic inject_err,
    output logic alert_n,
    output logic [31:0] n_cmds,
    output logic [25:0] last_cmd,
    output logic last_par_ok
);
    int alert_left = 0;
    logic par_bad;
    initial
    begin
        n_cmds = 32'h0;
        last_cmd = 26'h0;
        last_par_ok = 1'b0;
    end
    // Released alert goes back to its pull-up level
    assign alert_n = (alert_left == 0);
    assign par_bad = ((^{activate_n, addr, bg, ba, cmd_parity}) !== 1'b0);
    // A selected rank latches the command; a parity fault pulls alert low for a while
    always @(posedge link_clk)
    begin
        if ((&cs_n) === 1'b0)
        begin
            n_cmds <= n_cmds + 32'h1;
            last_cmd <= {cs_n, activate_n, bg, ba, addr};
            last_par_ok <= !par_bad;
            if (inject_err || par_bad)
                alert_left <= 8;
        end
        else if (alert_left > 0)
            alert_left <= alert_left - 1;
    end
endmodule : ddca_rank_model
`default_nettype wire

// ### verif/ddca_cmd_driver_test.sv
`timescale 1ns/1ns
`default_nettype none
module ddca_cmd_driver_test
    import ddca_pkg::*;
;
    logic clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, link_rst_n = 1'b0, ce = 1'b1;
    logic cmd_valid = 1'b0, cmd_chan = 1'b0, training_en = 1'b0, s3_entry = 1'b0, inject = 1'b0;
    ddca_op_t cmd_op = DDCA_OP_NOP;
    logic [1:0] cmd_rank = 2'h0, cmd_bg = 2'h0, cmd_ba = 2'h0;
    logic [16:0] cmd_addr = 17'h0;
    logic [3:0] idle_cstate = 4'h0;
    logic cmd_ready, a0_n, a1_n, act0_n, act1_n, par0, par1, err0, err1, term_en, ok0, ok1;
    logic [16:0] addr0, addr1;
    logic [1:0] bg0, bg1, ba0, ba1;
    logic [3:0] cs0_n, cs1_n;
    logic [31:0] n0, n1;
    logic [25:0] last0, last1;
    int n_errors = 0, n_checks = 0, pulses0 = 0, pulses1 = 0;

    initial
    begin
        forever #25 clk = ~clk;
    end
    initial
    begin
        #7;
        forever #24 link_clk = ~link_clk;
    end
    always @(posedge clk)
    begin
        if (err0 === 1'b1)
            pulses0++;
        if (err1 === 1'b1)
            pulses1++;
    end

    ddca_cmd_driver dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .link_clk(link_clk), .link_rst_n(link_rst_n),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_chan(cmd_chan), .cmd_op(cmd_op), .cmd_rank(cmd_rank),
        .cmd_bg(cmd_bg), .cmd_ba(cmd_ba), .cmd_addr(cmd_addr), .training_en(training_en),
        .idle_cstate(idle_cstate), .s3_entry(s3_entry), .chan0_alert_in_n(a0_n), .chan1_alert_in_n(a1_n),
        .chan0_activate_n(act0_n), .chan0_addr(addr0), .chan0_bg(bg0), .chan0_ba(ba0), .chan0_cs_n(cs0_n),
        .chan0_cmd_parity(par0), .chan0_ca_parity_err(err0), .chan1_activate_n(act1_n), .chan1_addr(addr1),
        .chan1_bg(bg1), .chan1_ba(ba1), .chan1_cs_n(cs1_n), .chan1_cmd_parity(par1),
        .chan1_ca_parity_err(err1), .term_regulator_enable(term_en));
    ddca_rank_model m0 (.link_clk(link_clk), .activate_n(act0_n), .addr(addr0), .bg(bg0), .ba(ba0),
        .cs_n(cs0_n), .cmd_parity(par0), .inject_err(inject), .alert_n(a0_n), .n_cmds(n0), .last_cmd(last0),
        .last_par_ok(ok0));
    ddca_rank_model m1 (.link_clk(link_clk), .activate_n(act1_n), .addr(addr1), .bg(bg1), .ba(ba1),
        .cs_n(cs1_n), .cmd_parity(par1), .inject_err(inject), .alert_n(a1_n), .n_cmds(n1), .last_cmd(last1),
        .last_par_ok(ok1));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    function automatic logic [25:0] exp_word(input ddca_op_t op, input logic [1:0] rank, input logic [1:0] bg,
                                             input logic [1:0] ba, input logic [16:0] addr);
        logic [16:0] a;
        logic [1:0] b;
        a = addr;
        b = bg;
        case (op)
            DDCA_OP_RD: a[16:14] = 3'h5;
            DDCA_OP_WR: a[16:14] = 3'h4;
            DDCA_OP_PRE: a[16:14] = 3'h2;
            DDCA_OP_PREA: a[16:14] = 3'h2;
            DDCA_OP_MRS: a[16:14] = 3'h0;
            DDCA_OP_REF: a[16:14] = 3'h1;
            default: a = addr;
        endcase
        if (op == DDCA_OP_PRE)
            a[10] = 1'b0;
        if (op == DDCA_OP_PREA)
            a[10] = 1'b1;
        if (op == DDCA_OP_MRS)
            b[1] = 1'b0;
        return {~(4'h1 << rank), op != DDCA_OP_ACT, b, ba, a};
    endfunction : exp_word

    // Sends one command, then waits for a rank to see it or for the wait to run out
    task automatic do_cmd(input logic ch, input ddca_op_t op, input logic [1:0] rank, input logic [1:0] bg,
                          input logic [1:0] ba, input logic [16:0] addr);
        int i;
        logic [31:0] c;
        i = 0;
        while (cmd_ready !== 1'b1 && i < 100)
        begin
            @(posedge clk);
            #2;
            i++;
        end
        if (i == 100)
            check(32'h0, 32'h1);
        cmd_chan = ch;
        cmd_op = op;
        cmd_rank = rank;
        cmd_bg = bg;
        cmd_ba = ba;
        cmd_addr = addr;
        cmd_valid = 1'b1;
        @(posedge clk);
        #2;
        cmd_valid = 1'b0;
        c = n0 + n1;
        i = 0;
        while ((n0 + n1) == c && i < 60)
        begin
            @(posedge clk);
            #2;
            i++;
        end
    endtask : do_cmd

    task automatic t_reset;
        check({cs0_n, act0_n, bg0, ba0, addr0}, {DDCA_CS_IDLE, 1'b1, DDCA_BG_IDLE, DDCA_BA_IDLE, DDCA_ADDR_IDLE});
        check(par0, ^{1'b1, DDCA_ADDR_IDLE, DDCA_BG_IDLE, DDCA_BA_IDLE});
        check(term_en, 1'b1);
    endtask : t_reset

    // Every command code but NOP on channel 0, A10 set against the forced value, MRS with BG1 set
    task automatic t_ops;
        logic [31:0] c;
        logic [16:0] a;
        for (int k = 0; k < 7; k++)
        begin
            c = n0;
            a = (k[0]) ? 17'h1a5a5 : 17'h05a5a;
            do_cmd(1'b0, ddca_op_t'(k), 2'(k), 2'(3 - k), 2'(k + 1), a);
            check(n0 - c, 32'h1);
            check(last0, exp_word(ddca_op_t'(k), 2'(k), 2'(3 - k), 2'(k + 1), a));
            check(ok0, 1'b1);
        end
    endtask : t_ops

    task automatic t_chan1_nop;
        logic [31:0] c;
        c = n0;
        do_cmd(1'b1, DDCA_OP_ACT, 2'h3, 2'h2, 2'h1, 17'h1ffff);
        check(last1, exp_word(DDCA_OP_ACT, 2'h3, 2'h2, 2'h1, 17'h1ffff));
        check(ok1, 1'b1);
        check(n0, c);
        c = n0 + n1;
        do_cmd(1'b0, DDCA_OP_NOP, 2'h1, 2'h0, 2'h0, 17'h0);
        check(n0 + n1, c);
    endtask : t_chan1_nop

    // Alert faults count only in training, and on the channel that saw them
    task automatic t_alert;
        int p0, p1;
        inject = 1'b1;
        for (int t = 0; t < 2; t++)
        begin
            for (int ch = 0; ch < 2; ch++)
            begin
                training_en = t[0];
                p0 = pulses0;
                p1 = pulses1;
                do_cmd(ch[0], DDCA_OP_ACT, 2'h0, 2'h1, 2'h2, 17'h00123);
                repeat (30) @(posedge clk);
                #2;
                check(pulses0 - p0, (t == 1 && ch == 0) ? 32'h1 : 32'h0);
                check(pulses1 - p1, (t == 1 && ch == 1) ? 32'h1 : 32'h0);
            end
        end
        inject = 1'b0;
        training_en = 1'b0;
    endtask : t_alert

    task automatic t_vtt;
        logic [5:0] tbl [7] = '{6'h01, 6'h0f, 6'h10, 6'h1e, 6'h07, 6'h21, 6'h01};
        for (int k = 0; k < 7; k++)
        begin
            idle_cstate = tbl[k][4:1];
            s3_entry = tbl[k][5];
            repeat (3) @(posedge clk);
            #2;
            check(term_en, tbl[k][4:1] < 4'h8 && !tbl[k][5]);
        end
        // Clock enable low freezes the regulator control until it runs again
        ce = 1'b0;
        idle_cstate = 4'h9;
        repeat (3) @(posedge clk);
        #2;
        check(term_en, 1'b1);
        ce = 1'b1;
        repeat (3) @(posedge clk);
        #2;
        check(term_en, 1'b0);
        idle_cstate = 4'h0;
    endtask : t_vtt

    initial
    begin
        #1_000_000;
        n_errors++;
        stop_test();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        #2;
        t_reset();
        rst_n = 1'b1;
        link_rst_n = 1'b1;
        t_ops();
        t_chan1_nop();
        t_alert();
        t_vtt();
        stop_test();
    end
endmodule : ddca_cmd_driver_test
`default_nettype wire
